/* File: rtl/vpcm_bclk_gen.sv */
// bit-clock divider for master mode, system clock domain
`timescale 1ns/1ns
module vpcm_bclk_gen import vpcm_pkg::*; #(
    parameter int NB_HALF = VPCM_NB_HALF,
    parameter int WB_HALF = VPCM_WB_HALF
) (
    input wire logic clk,
    input wire logic rst_n,
    vpcm_clk_if.gen cif
);
    localparam int NB_H = NB_HALF;
    localparam int WB_H = WB_HALF;
    // the divider counter is eight bits wide, so a longer half period cannot be counted
    if (NB_HALF < 1 || WB_HALF < 1 || NB_HALF > 255 || WB_HALF > 255) begin : g_bad_half
        $error("vpcm_bclk_gen: half period out of range");
    end

    typedef struct packed {
        logic [VPCM_DIV_W-1:0] cnt;
        logic bclk;
    } vpcm_div_s;

    vpcm_div_s r, next_r;
    logic [VPCM_DIV_W-1:0] half;

    always_comb begin
        next_r = r;
        half = cif.wide ? VPCM_DIV_W'(WB_HALF - 1) : VPCM_DIV_W'(NB_HALF - 1);
        if (!cif.run) begin
            next_r.cnt = VPCM_DIV_RST;
            next_r.bclk = 1'b0;
        end else if (r.cnt >= half) begin
            // fixed mark/space: both halves the same length
            next_r.cnt = VPCM_DIV_RST;
            next_r.bclk = ~r.bclk;
        end else begin
            next_r.cnt = r.cnt + VPCM_DIV_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign cif.bclk = r.bclk;

    property p_nb_rate;
        @(posedge clk) disable iff (!rst_n)
        ($changed(r.bclk) && cif.run && !cif.wide) |->
            ##NB_H ($changed(r.bclk) || !cif.run || cif.wide);
    endproperty
    a_nb_rate: assert property (p_nb_rate) else $error("narrowband bit clock period wrong");

    property p_wb_rate;
        @(posedge clk) disable iff (!rst_n)
        ($changed(r.bclk) && cif.run && cif.wide) |->
            ##WB_H ($changed(r.bclk) || !cif.run || !cif.wide);
    endproperty
    a_wb_rate: assert property (p_wb_rate) else $error("wideband bit clock period wrong");
endmodule // vpcm_bclk_gen

/* File: rtl/vpcm_clk_if.sv */
// carrier between the port top and its bit-clock divider
`timescale 1ns/1ns
interface vpcm_clk_if;
    logic run;
    logic wide;
    logic bclk;
    modport gen (input run, input wide, output bclk);
    modport ctl (output run, output wide, input bclk);
endinterface

/* File: rtl/vpcm_pkg.sv */
// constants and types shared by the voice pcm port
package vpcm_pkg;
    localparam int VPCM_SYS_HZ = 100_000_000;
    localparam int VPCM_FRAME_BITS = 32;
    localparam int VPCM_SLOT_BITS = 16;
    localparam int VPCM_NB_RATE_HZ = 8000;
    localparam int VPCM_WB_RATE_HZ = 16000;
    // half bit-clock periods in system cycles, rounded down
    localparam int VPCM_NB_HALF = VPCM_SYS_HZ / (2 * VPCM_FRAME_BITS * VPCM_NB_RATE_HZ);
    localparam int VPCM_WB_HALF = VPCM_SYS_HZ / (2 * VPCM_FRAME_BITS * VPCM_WB_RATE_HZ);
    localparam int VPCM_DIV_W = 8;
    localparam logic [4:0] VPCM_CNT_RST = 5'h00;
    localparam logic [4:0] VPCM_MSB_POS = 5'h01;
    localparam logic [4:0] VPCM_SLOT_END = 5'h10;
    localparam logic [15:0] VPCM_WORD_RST = 16'h0000;
    localparam logic [7:0] VPCM_DIV_RST = 8'h00;
    localparam int VPCM_NPAD = 2;
    typedef enum logic {VPCM_PAD_DED, VPCM_PAD_AUD} vpcm_pad_e;
endpackage

/* File: rtl/vpcm_port.sv */
// voice pcm port top: configuration, master clocking and i2s-style link engine
`timescale 1ns/1ns
module vpcm_port import vpcm_pkg::*; #(
    parameter int NB_HALF = VPCM_NB_HALF,
    parameter int WB_HALF = VPCM_WB_HALF
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    input wire logic LINK_CLK_I,
    input wire logic CFG_LOAD_I,
    input wire logic CFG_MASTER_I,
    input wire logic CFG_ENABLE_I,
    input wire logic CFG_WIDEBAND_I,
    input wire logic CFG_PAD_AUD_I,
    input wire logic [15:0] TX_SAMPLE_I,
    output logic [15:0] RX_SAMPLE_O,
    output logic RX_VALID_O,
    output logic TX_TAKEN_O,
    output logic STAT_MASTER_O,
    output logic STAT_ENABLE_O,
    output logic STAT_WIDEBAND_O,
    output logic STAT_PAD_AUD_O,
    output logic DED_BCLK_O,
    output logic DED_BCLK_OE_O,
    input wire logic DED_WS_I,
    output logic DED_WS_O,
    output logic DED_WS_OE_O,
    output logic DED_SDO_O,
    output logic DED_SDO_OE_O,
    input wire logic DED_SDI_I,
    output logic AUD_BCLK_O,
    output logic AUD_BCLK_OE_O,
    input wire logic AUD_WS_I,
    output logic AUD_WS_O,
    output logic AUD_WS_OE_O,
    output logic AUD_SDO_O,
    output logic AUD_SDO_OE_O,
    input wire logic AUD_SDI_I
);
    // ---------------- system clock domain ----------------
    typedef struct packed {
        logic cfg_master;
        logic cfg_en;
        logic cfg_wide;
        vpcm_pad_e cfg_pad;
        logic tgl_s1;
        logic tgl_s2;
        logic tgl_s3;
        logic act_s1;
        logic act_s2;
        logic [15:0] rx_sample;
        logic rx_valid;
        logic tx_taken;
        logic [15:0] tx_hold;
        logic [VPCM_NPAD-1:0] bclk;
        logic [VPCM_NPAD-1:0] bclk_oe;
    } vpcm_sys_s;

    // ---------------- link clock domain ----------------
    typedef struct packed {
        logic mst_s1;
        logic mst_s2;
        logic en_s1;
        logic en_s2;
        logic pad_s1;
        logic pad_s2;
        logic [4:0] cnt;
        logic ws;
        logic ws_last;
        logic [15:0] tx_sh;
        logic [15:0] rx_sh;
        logic [15:0] rx_word;
        logic tgl;
        logic act;
        logic [VPCM_NPAD-1:0] ws_o;
        logic [VPCM_NPAD-1:0] ws_oe;
        logic [VPCM_NPAD-1:0] sdo;
        logic [VPCM_NPAD-1:0] sdo_oe;
    } vpcm_link_s;

    vpcm_sys_s s, next_s;
    vpcm_link_s l, next_l;
    logic ws_in_r;
    logic sdi_r;

    vpcm_clk_if cif ();

    vpcm_bclk_gen #(
        .NB_HALF(NB_HALF),
        .WB_HALF(WB_HALF)
    ) u_bclk (
        .clk(SYS_CLK_I),
        .rst_n(RST_N_I),
        .cif(cif)
    );

    // the bit clock runs on after a disable until the link has parked its outputs,
    // otherwise the link would freeze with its drivers still enabled
    assign cif.run = s.cfg_master && (s.cfg_en || s.act_s2);
    assign cif.wide = s.cfg_wide;

    always_comb begin
        next_s = s;
        next_s.rx_valid = 1'b0;
        next_s.tx_taken = 1'b0;
        if (CFG_LOAD_I) begin
            next_s.cfg_master = CFG_MASTER_I;
            next_s.cfg_en = CFG_ENABLE_I;
            next_s.cfg_wide = CFG_WIDEBAND_I;
            next_s.cfg_pad = CFG_PAD_AUD_I ? VPCM_PAD_AUD : VPCM_PAD_DED;
        end
        next_s.tgl_s1 = l.tgl;
        next_s.tgl_s2 = s.tgl_s1;
        next_s.tgl_s3 = s.tgl_s2;
        next_s.act_s1 = l.act;
        next_s.act_s2 = s.act_s1;
        if (s.tgl_s2 != s.tgl_s3) begin
            // the link holds rx_word for a whole frame and reads tx_hold
            // sixteen bit clocks later, so both words are quiet here
            next_s.rx_sample = l.rx_word;
            next_s.rx_valid = 1'b1;
            next_s.tx_hold = TX_SAMPLE_I;
            next_s.tx_taken = 1'b1;
        end
        for (int p = 0; p < VPCM_NPAD; p++) begin
            next_s.bclk[p] = cif.bclk && (s.cfg_pad == vpcm_pad_e'(p));
            next_s.bclk_oe[p] = cif.run && (s.cfg_pad == vpcm_pad_e'(p));
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // link inputs are launched on the falling edge, so catch them on the rising one
    always_ff @(posedge LINK_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ws_in_r <= 1'b0;
            sdi_r <= 1'b0;
        end else begin
            ws_in_r <= l.pad_s2 ? AUD_WS_I : DED_WS_I;
            sdi_r <= l.pad_s2 ? AUD_SDI_I : DED_SDI_I;
        end
    end

    always_comb begin
        next_l = l;
        next_l.mst_s1 = s.cfg_master;
        next_l.mst_s2 = l.mst_s1;
        next_l.en_s1 = s.cfg_en;
        next_l.en_s2 = l.en_s1;
        next_l.pad_s1 = (s.cfg_pad == VPCM_PAD_AUD);
        next_l.pad_s2 = l.pad_s1;
        next_l.cnt = l.cnt + 5'h01;
        next_l.ws_last = ws_in_r;
        next_l.act = l.en_s2;
        if (!l.mst_s2 && l.ws_last && !ws_in_r) begin
            // word select fell one edge ago: this edge drives the msb
            next_l.cnt = VPCM_MSB_POS;
        end
        if (!l.en_s2) begin
            next_l.cnt = VPCM_CNT_RST;
        end
        next_l.ws = l.en_s2 && l.mst_s2 && (next_l.cnt >= VPCM_SLOT_END);
        if (next_l.cnt == VPCM_MSB_POS) begin
            next_l.tx_sh = s.tx_hold;
        end else begin
            next_l.tx_sh = {l.tx_sh[14:0], 1'b0};
        end
        if (l.en_s2 && l.cnt >= VPCM_MSB_POS && l.cnt <= VPCM_SLOT_END) begin
            next_l.rx_sh = {l.rx_sh[14:0], sdi_r};
            if (l.cnt == VPCM_SLOT_END) begin
                // right slot bits are never shifted in
                next_l.rx_word = {l.rx_sh[14:0], sdi_r};
                next_l.tgl = ~l.tgl;
            end
        end
        for (int p = 0; p < VPCM_NPAD; p++) begin
            next_l.ws_o[p] = next_l.ws && (l.pad_s2 == p[0]);
            next_l.ws_oe[p] = l.en_s2 && l.mst_s2 && (l.pad_s2 == p[0]);
            next_l.sdo[p] = l.en_s2 && (l.pad_s2 == p[0]) && next_l.tx_sh[15]
                && (next_l.cnt >= VPCM_MSB_POS) && (next_l.cnt <= VPCM_SLOT_END);
            next_l.sdo_oe[p] = l.en_s2 && (l.pad_s2 == p[0]);
        end
    end

    // everything the link drives moves on the falling bit-clock edge
    always_ff @(negedge LINK_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    assign RX_SAMPLE_O = s.rx_sample;
    assign RX_VALID_O = s.rx_valid;
    assign TX_TAKEN_O = s.tx_taken;
    assign STAT_MASTER_O = s.cfg_master;
    assign STAT_ENABLE_O = s.cfg_en;
    assign STAT_WIDEBAND_O = s.cfg_wide;
    assign STAT_PAD_AUD_O = (s.cfg_pad == VPCM_PAD_AUD);
    assign DED_BCLK_O = s.bclk[VPCM_PAD_DED];
    assign DED_BCLK_OE_O = s.bclk_oe[VPCM_PAD_DED];
    assign AUD_BCLK_O = s.bclk[VPCM_PAD_AUD];
    assign AUD_BCLK_OE_O = s.bclk_oe[VPCM_PAD_AUD];
    assign DED_WS_O = l.ws_o[VPCM_PAD_DED];
    assign DED_WS_OE_O = l.ws_oe[VPCM_PAD_DED];
    assign AUD_WS_O = l.ws_o[VPCM_PAD_AUD];
    assign AUD_WS_OE_O = l.ws_oe[VPCM_PAD_AUD];
    assign DED_SDO_O = l.sdo[VPCM_PAD_DED];
    assign DED_SDO_OE_O = l.sdo_oe[VPCM_PAD_DED];
    assign AUD_SDO_O = l.sdo[VPCM_PAD_AUD];
    assign AUD_SDO_OE_O = l.sdo_oe[VPCM_PAD_AUD];

    // ---------------- checks ----------------
    property p_cfg_load;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        CFG_LOAD_I |=> (STAT_MASTER_O == $past(CFG_MASTER_I))
            && (STAT_WIDEBAND_O == $past(CFG_WIDEBAND_I))
            && (STAT_ENABLE_O == $past(CFG_ENABLE_I));
    endproperty
    a_cfg_load: assert property (p_cfg_load) else $error("config not taken on load");

    property p_master_bclk;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (s.cfg_master && s.cfg_en) |=> (DED_BCLK_OE_O || AUD_BCLK_OE_O)
            && !(DED_BCLK_OE_O && AUD_BCLK_OE_O);
    endproperty
    a_master_bclk: assert property (p_master_bclk) else $error("master bit clock not driven");

    sequence s_frame_seen;
        s.tgl_s2 != s.tgl_s3;
    endsequence

    property p_sample_pass;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        s_frame_seen |=> RX_VALID_O && TX_TAKEN_O && (RX_SAMPLE_O == $past(l.rx_word))
            && (s.tx_hold == $past(TX_SAMPLE_I));
    endproperty
    a_sample_pass: assert property (p_sample_pass) else $error("frame sample not exchanged");

    sequence s_ws_fall;
        l.mst_s2 && l.en_s2 && $fell(l.ws);
    endsequence

    property p_ws_frame;
        @(negedge LINK_CLK_I) disable iff (!RST_N_I)
        s_ws_fall |-> (l.cnt == VPCM_CNT_RST) ##16 (l.ws && l.cnt == VPCM_SLOT_END);
    endproperty
    a_ws_frame: assert property (p_ws_frame) else $error("word select slot length wrong");

    property p_left_low;
        @(negedge LINK_CLK_I) disable iff (!RST_N_I)
        s_ws_fall |=> (!l.ws)[*8];
    endproperty
    a_left_low: assert property (p_left_low) else $error("word select not low in left slot");

    property p_msb_delay;
        @(negedge LINK_CLK_I) disable iff (!RST_N_I)
        s_ws_fall |=> (l.cnt == VPCM_MSB_POS) && (l.sdo[l.pad_s2] == s.tx_hold[15]);
    endproperty
    a_msb_delay: assert property (p_msb_delay) else $error("msb not one clock after ws");

    property p_right_quiet;
        @(negedge LINK_CLK_I) disable iff (!RST_N_I)
        (l.cnt > VPCM_SLOT_END) |-> (l.sdo == '0);
    endproperty
    a_right_quiet: assert property (p_right_quiet) else $error("data sent in right slot");

    property p_rx_capture;
        @(negedge LINK_CLK_I) disable iff (!RST_N_I)
        (l.en_s2 && l.cnt == VPCM_SLOT_END) |=>
            (l.rx_word == {$past(l.rx_sh[14:0]), $past(sdi_r)}) && (l.tgl != $past(l.tgl));
    endproperty
    a_rx_capture: assert property (p_rx_capture) else $error("received word not captured");

    property p_slave_quiet;
        @(negedge LINK_CLK_I) disable iff (!RST_N_I)
        !l.mst_s2 |=> (l.ws_oe == '0);
    endproperty
    a_slave_quiet: assert property (p_slave_quiet) else $error("slave drives word select");

    property p_slave_lock;
        @(negedge LINK_CLK_I) disable iff (!RST_N_I)
        (!l.mst_s2 && l.en_s2 && l.ws_last && !ws_in_r) |=> (l.cnt == VPCM_MSB_POS);
    endproperty
    a_slave_lock: assert property (p_slave_lock) else $error("slave not aligned to ws");

    property p_pad_split;
        @(negedge LINK_CLK_I) disable iff (!RST_N_I)
        l.pad_s2 |=> !DED_WS_OE_O && !DED_SDO_OE_O && !DED_SDO_O;
    endproperty
    a_pad_split: assert property (p_pad_split) else $error("dedicated pads active");
endmodule // vpcm_port

/* File: verification/tb_top.sv */
// self-checking bench for the voice pcm port
`timescale 1ns/1ns
module tb_top;
    localparam int NBH = 4;
    localparam int WBH = 2;
    logic SYS_CLK_I = 1'b0, RST_N_I = 1'b0, LINK_CLK_I, CFG_LOAD_I = 1'b0;
    logic CFG_MASTER_I = 1'b0, CFG_ENABLE_I = 1'b0, CFG_WIDEBAND_I = 1'b0, CFG_PAD_AUD_I = 1'b0;
    logic [15:0] TX_SAMPLE_I = 16'h0000, RX_SAMPLE_O, cd_tx = 16'h0000, cd_got;
    logic RX_VALID_O, TX_TAKEN_O, STAT_MASTER_O, STAT_ENABLE_O, STAT_WIDEBAND_O, STAT_PAD_AUD_O;
    logic DED_BCLK_O, DED_BCLK_OE_O, DED_WS_I, DED_WS_O, DED_WS_OE_O, DED_SDO_O, DED_SDO_OE_O;
    logic DED_SDI_I, AUD_BCLK_O, AUD_BCLK_OE_O, AUD_WS_I, AUD_WS_O, AUD_WS_OE_O, AUD_SDO_O;
    logic AUD_SDO_OE_O, AUD_SDI_I, cd_clk, cd_ws, cd_sd, sdo_r, live = 1'b0;
    int fail_count = 0;
    int cmp_count = 0;
    wire logic p = CFG_PAD_AUD_I;
    wire logic sdo_w = p ? AUD_SDO_O : DED_SDO_O;
    always #5 SYS_CLK_I = ~SYS_CLK_I;
    assign LINK_CLK_I = CFG_MASTER_I ? (p ? AUD_BCLK_O : DED_BCLK_O) : cd_clk;
    // the pad set not in use sees inverted traffic, so a wrong mux shows
    assign DED_WS_I = p ? ~cd_ws : cd_ws;
    assign AUD_WS_I = p ? cd_ws : ~cd_ws;
    assign DED_SDI_I = p ? ~cd_sd : cd_sd;
    assign AUD_SDI_I = p ? cd_sd : ~cd_sd;
    vpcm_codec cd (.run_i(!CFG_MASTER_I && CFG_ENABLE_I), .lclk_i(LINK_CLK_I),
        .ws_i(CFG_MASTER_I ? (p ? AUD_WS_O : DED_WS_O) : cd_ws), .sd_i(sdo_w),
        .tx_i(cd_tx), .lclk_o(cd_clk), .ws_o(cd_ws), .sd_o(cd_sd), .got_o(cd_got));
    vpcm_port #(.NB_HALF(NBH), .WB_HALF(WBH)) uut (.*);

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic tick;
        @(posedge SYS_CLK_I);
        #1;
    endtask

    task automatic wait_pulse(output int n);
        n = 0;
        do begin
            tick();
            n++;
            if (n > 4000) begin
                check(16'h0000, 16'h0001);
                conclude();
            end
        end while (RX_VALID_O !== 1'b1);
    endtask

    task automatic configure(input logic m, input logic w, input logic pa, input logic en);
        tick();
        {CFG_MASTER_I, CFG_WIDEBAND_I, CFG_PAD_AUD_I, CFG_ENABLE_I} = {m, w, pa, en};
        CFG_LOAD_I = 1'b1;
        tick();
        CFG_LOAD_I = 1'b0;
        check(16'({STAT_MASTER_O, STAT_WIDEBAND_O, STAT_PAD_AUD_O, STAT_ENABLE_O}),
            16'({m, w, pa, en}));
    endtask

    // data on the wire must hold across the sampling edge
    always @(posedge LINK_CLK_I) begin
        sdo_r = sdo_w;
        #4;
        if (live) check(16'(sdo_w), 16'(sdo_r));
    end

    task automatic stream(input logic m, input logic w, input logic pa);
        logic [15:0] lat;
        logic [15:0] prv = 16'h0000;
        logic [15:0] cprv = 16'h0000;
        int n;
        configure(m, w, pa, 1'b1);
        for (int k = 0; k < 7; k++) begin
            wait_pulse(n);
            lat = TX_SAMPLE_I;
            if (k > 2) begin
                check(16'(TX_TAKEN_O), 16'h0001);
                check(cd_got, prv);
                check(RX_SAMPLE_O, cprv);
                check(16'({DED_BCLK_OE_O, DED_WS_OE_O, DED_SDO_OE_O, AUD_BCLK_OE_O,
                    AUD_WS_OE_O, AUD_SDO_OE_O}),
                    16'(pa ? {3'b000, m, m, 1'b1} : {m, m, 1'b1, 3'b000}));
                if (m) check(16'(n), 16'(64 * (w ? WBH : NBH) - 1));
                else check(16'(n > 151 && n < 154), 16'h0001);
            end
            live = k > 1;
            prv = lat;
            TX_SAMPLE_I = 16'h8001 + 16'(k) * 16'h2469 + {5'h00, m, 10'h000};
            // the codec sends its word in the very next frame, unlike the port
            cd_tx = ~TX_SAMPLE_I ^ {w, pa, 14'h0155};
            cprv = cd_tx;
            tick();
            check(16'({RX_VALID_O, TX_TAKEN_O}), 16'h0000);
        end
        live = 1'b0;
        $display("stream test master=%0d wide=%0d pad=%0d done", m, w, pa);
    endtask

    task automatic idle_check;
        int n = 0;
        configure(1'b1, 1'b0, 1'b0, 1'b0);
        // the port clocks its link for a few bit times after a disable to park it
        repeat (60) tick();
        repeat (600) begin
            tick();
            if (RX_VALID_O !== 1'b0 || DED_BCLK_OE_O !== 1'b0 || DED_SDO_OE_O !== 1'b0) n++;
        end
        check(16'(n), 16'h0000);
        $display("disable test done");
    endtask

    initial begin
        repeat (2) @(posedge SYS_CLK_I);
        #1;
        RST_N_I = 1'b1;
        check(16'({STAT_MASTER_O, STAT_ENABLE_O, STAT_WIDEBAND_O, STAT_PAD_AUD_O,
            DED_BCLK_OE_O, DED_SDO_OE_O, AUD_SDO_OE_O, RX_VALID_O}), 16'h0000);
        $display("reset test done");
        stream(1'b1, 1'b0, 1'b0);
        stream(1'b1, 1'b1, 1'b1);
        stream(1'b0, 1'b0, 1'b1);
        stream(1'b0, 1'b1, 1'b0);
        idle_check();
        conclude();
    end
endmodule // tb_top

/* File: verification/vpcm_codec.sv */
// linear codec model on the far side of the voice port link
`timescale 1ns/1ns
module vpcm_codec (
    input wire logic run_i,
    input wire logic lclk_i,
    input wire logic ws_i,
    input wire logic sd_i,
    input wire logic [15:0] tx_i,
    output logic lclk_o,
    output logic ws_o,
    output logic sd_o,
    output logic [15:0] got_o
);
    logic [4:0] mpos = 5'h1f;
    logic [4:0] pos = 5'h1f;
    logic [15:0] sh = 16'h0000;
    logic wsp = 1'b0;
    logic fall;
    initial begin
        lclk_o = 1'b0;
        ws_o = 1'b1;
        sd_o = 1'b0;
        got_o = 16'h0000;
    end
    // clock parks low between sessions so no stray edge reaches the port
    always #24 if (run_i || lclk_o) lclk_o = ~lclk_o;
    always @(negedge lclk_o) begin
        mpos <= mpos + 5'h01;
        ws_o <= (mpos + 5'h01) >= 5'h10;
    end
    assign fall = wsp && !ws_i;
    always @(posedge lclk_i) begin
        wsp <= ws_i;
        pos <= fall ? 5'h00 : pos + 5'h01;
        if (!fall && pos < 5'h10) begin
            sh <= {sh[14:0], sd_i};
            if (pos == 5'h0f) got_o <= {sh[14:0], sd_i};
        end
    end
    // right slot toggles so a port that reads it gets no stable value
    always @(negedge lclk_i) begin
        if (pos < 5'h10) sd_o <= tx_i[5'h0f - pos];
        else sd_o <= ~sd_o;
    end
endmodule // vpcm_codec
